/* File: design/gpm_pin_mux.sv */
`timescale 1ns/10ps
`default_nettype none

module gpm_pin_mux
  import gpm_pkg::*;
(
  input  wire logic                 clk_i,
  input  wire logic                 reset_i,
  input  wire gpm_sfr_req_t         sfr_i,
  output logic [7:0]                sfr_rdata_o,
  output logic                      sfr_hit_o,
  input  wire logic [7:0]           port3_cfg_i,
  input  wire logic [GPM_NPINS-1:0] port_data_i,
  input  wire gpm_periph_out_t      periph_i,
  output gpm_periph_in_t            periph_o,
  input  wire logic [GPM_NPINS-1:0] pin_i,
  output logic [GPM_NPINS-1:0]      pin_o,
  output logic [GPM_NPINS-1:0]      pin_oe_o,
  output logic [GPM_NPINS-1:0]      port_read_o
);

  gpm_state_t s_q;
  gpm_state_t s_d;

  function automatic logic pick(input logic en, input logic periph, input logic gpio);
    pick = en ? periph : gpio;
  endfunction

  always_comb begin
    logic [GPM_NPINS-1:0] oe;
    logic [GPM_NPINS-1:0] dout;
    oe   = '0;
    dout = '0;
    s_d  = s_q;
    s_d.rdata = GPM_RDATA_UNMAPPED;
    s_d.hit   = 1'b0;
    if (sfr_i.rd) begin
      if (sfr_i.addr == GPM_PORT0_CFG_ADDR) begin
        s_d.rdata = s_q.cfg0; // RL18
        s_d.hit   = 1'b1;
      end else if (sfr_i.addr == GPM_PORT1_CFG_ADDR) begin
        s_d.rdata = s_q.cfg1; // RL18
        s_d.hit   = 1'b1;
      end else if (sfr_i.addr == GPM_PORT2_CFG_ADDR) begin
        s_d.rdata = s_q.cfg2; // RL18
        s_d.hit   = 1'b1;
      end
    end
    if (sfr_i.wr) begin
      if (sfr_i.addr == GPM_PORT0_CFG_ADDR) begin
        s_d.cfg0 = sfr_i.wdata; // RL18
      end else if (sfr_i.addr == GPM_PORT1_CFG_ADDR) begin
        s_d.cfg1 = sfr_i.wdata; // RL18
      end else if (sfr_i.addr == GPM_PORT2_CFG_ADDR) begin
        s_d.cfg2 = sfr_i.wdata; // RL18
      end
    end

    // Upper nibbles of port 0 and port 1 are stored but reach no pin
    oe   = {port3_cfg_i, s_q.cfg2, s_q.cfg1[3:0], s_q.cfg0[3:0]}; // RL2 RL4 RL12 RL15
    dout = port_data_i; // RL16 RL3

    dout[GPM_PIN_UB_TX] = pick(periph_i.uart_b_en, periph_i.uart_b_tx,
                               port_data_i[GPM_PIN_UB_TX]); // RL9
    for (int k = 0; k < 4; k++) begin
      dout[GPM_PIN_PWM0 + k] = pick(periph_i.pwm_en, periph_i.pwm[k],
                                    port_data_i[GPM_PIN_PWM0 + k]); // RL13
      dout[GPM_PIN_CS0 - k]  = pick(periph_i.spi_en, periph_i.spi_cs[k],
                                    port_data_i[GPM_PIN_CS0 - k]); // RL15
    end
    dout[GPM_PIN_SDO] = pick(periph_i.spi_en, periph_i.spi_sdo,
                             port_data_i[GPM_PIN_SDO]); // RL15
    dout[GPM_PIN_SCK] = pick(periph_i.spi_en, periph_i.spi_sck,
                             port_data_i[GPM_PIN_SCK]); // RL5

    // I2C lines are open drain: driven low only while the I2C logic pulls
    if (periph_i.i2c_en) begin
      oe[GPM_PIN_I2C_SCL]   = periph_i.i2c_scl_oe; // RL7
      oe[GPM_PIN_I2C_SDA]   = periph_i.i2c_sda_oe; // RL7
      dout[GPM_PIN_I2C_SCL] = 1'b0;
      dout[GPM_PIN_I2C_SDA] = 1'b0;
    end

    s_d.pin_out   = dout;
    s_d.pin_oe    = oe;
    s_d.port_read = (pin_i & ~oe) | (port_data_i & oe); // RL17 RL3

    s_d.pin_in.uart_b_rx   = pin_i[GPM_PIN_UB_RX];  // RL8
    s_d.pin_in.timer_b_ext = pin_i[GPM_PIN_TB_EXT]; // RL10
    s_d.pin_in.timer_b_cnt = pin_i[GPM_PIN_TB_CNT]; // RL11
    s_d.pin_in.spi_sdi     = pin_i[GPM_PIN_SDI];    // RL15
    s_d.pin_in.spi_sck     = pin_i[GPM_PIN_SCK];
    s_d.pin_in.spi_ss      = pin_i[GPM_PIN_SS];
    s_d.pin_in.i2c_scl     = pin_i[GPM_PIN_I2C_SCL];
    s_d.pin_in.i2c_sda     = pin_i[GPM_PIN_I2C_SDA];
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      s_q       <= '0;
      s_q.cfg0  <= GPM_CFG_RESET; // RL1 RL18
      s_q.cfg1  <= GPM_CFG_RESET; // RL1 RL18
      s_q.cfg2  <= GPM_CFG_RESET; // RL1 RL18
    end else begin
      s_q <= s_d;
    end
  end

  assign sfr_rdata_o = s_q.rdata;
  assign sfr_hit_o   = s_q.hit;
  assign pin_o       = s_q.pin_out;
  assign pin_oe_o    = s_q.pin_oe;
  assign port_read_o = s_q.port_read;
  assign periph_o    = s_q.pin_in;

  property p_reset_inputs;
    @(posedge clk_i) reset_i |=> (pin_oe_o == '0 && sfr_rdata_o == 8'h00);
  endproperty
  a_reset_inputs: assert property (p_reset_inputs) // RL1
    else $error("pins not all inputs after reset");

  property p_port0_dir;
    @(posedge clk_i) disable iff (reset_i)
      (sfr_i.wr && sfr_i.addr == GPM_PORT0_CFG_ADDR)
      |=> ##1 (pin_oe_o[3:0] == $past(sfr_i.wdata[3:0], 2));
  endproperty
  a_port0_dir: assert property (p_port0_dir) // RL8
    else $error("port 0 direction does not follow configuration");

  property p_upper_nibble;
    @(posedge clk_i) disable iff (reset_i)
      (sfr_i.wr && sfr_i.addr == GPM_PORT1_CFG_ADDR && !$past(sfr_i.wr))
      |=> ##1 (pin_oe_o[7:4] == $past(sfr_i.wdata[3:0], 2) && $stable(pin_oe_o[3:0]));
  endproperty
  a_upper_nibble: assert property (p_upper_nibble) // RL12
    else $error("port 1 configuration mapped to wrong pins");

  property p_uart_tx;
    @(posedge clk_i) disable iff (reset_i || $past(reset_i))
      pin_oe_o[GPM_PIN_UB_TX] |-> pin_o[GPM_PIN_UB_TX] ==
        ($past(periph_i.uart_b_en) ? $past(periph_i.uart_b_tx)
                                   : $past(port_data_i[GPM_PIN_UB_TX]));
  endproperty
  a_uart_tx: assert property (p_uart_tx) // RL9
    else $error("transmit pin carries wrong source");

  property p_timer_inputs;
    @(posedge clk_i) disable iff (reset_i || $past(reset_i))
      1'b1 |-> (periph_o.timer_b_ext == $past(pin_i[GPM_PIN_TB_EXT]) &&
                periph_o.timer_b_cnt == $past(pin_i[GPM_PIN_TB_CNT]));
  endproperty
  a_timer_inputs: assert property (p_timer_inputs) // RL10
    else $error("timer inputs do not follow their pins");

  property p_pwm_out;
    @(posedge clk_i) disable iff (reset_i || $past(reset_i))
      $past(periph_i.pwm_en) |-> pin_o[7:4] == $past(periph_i.pwm);
  endproperty
  a_pwm_out: assert property (p_pwm_out) // RL13
    else $error("PWM waveform not on port 1 pins");

  property p_spi_clock;
    @(posedge clk_i) disable iff (reset_i || $past(reset_i))
      (pin_oe_o[GPM_PIN_SCK] && $past(periph_i.spi_en))
      |-> pin_o[GPM_PIN_SCK] == $past(periph_i.spi_sck);
  endproperty
  a_spi_clock: assert property (p_spi_clock) // RL5
    else $error("SPI clock not on port 2 bit 5");

  property p_i2c_dir;
    @(posedge clk_i) disable iff (reset_i)
      periph_i.i2c_en |=> (pin_oe_o[GPM_PIN_I2C_SCL] == $past(periph_i.i2c_scl_oe) &&
                           pin_oe_o[GPM_PIN_I2C_SDA] == $past(periph_i.i2c_sda_oe) &&
                           !pin_o[GPM_PIN_I2C_SCL] && !pin_o[GPM_PIN_I2C_SDA]);
  endproperty
  a_i2c_dir: assert property (p_i2c_dir) // RL7
    else $error("I2C pin direction not under I2C control");

  property p_read_inputs;
    @(posedge clk_i) disable iff (reset_i || $past(reset_i))
      1'b1 |-> ((port_read_o ^ $past(pin_i)) & ~pin_oe_o) == '0;
  endproperty
  a_read_inputs: assert property (p_read_inputs) // RL17
    else $error("port read differs from input pin level");

  property p_cfg_readback;
    @(posedge clk_i) disable iff (reset_i)
      (sfr_i.wr && sfr_i.addr == GPM_PORT2_CFG_ADDR)
      ##1 (sfr_i.rd && !sfr_i.wr && sfr_i.addr == GPM_PORT2_CFG_ADDR)
      |=> (sfr_hit_o && sfr_rdata_o == $past(sfr_i.wdata, 2));
  endproperty
  a_cfg_readback: assert property (p_cfg_readback) // RL18
    else $error("configuration readback mismatch");

  property p_spi_selects;
    @(posedge clk_i) disable iff (reset_i || $past(reset_i))
      $past(periph_i.spi_en) |-> pin_o[11:8] == {$past(periph_i.spi_cs[0]),
        $past(periph_i.spi_cs[1]), $past(periph_i.spi_cs[2]), $past(periph_i.spi_cs[3])};
  endproperty
  a_spi_selects: assert property (p_spi_selects) // RL15
    else $error("SPI chip selects on wrong pins");

  property p_plain_data;
    @(posedge clk_i) disable iff (reset_i || $past(reset_i))
      1'b1 |-> (pin_o[21:15] == $past(port_data_i[21:15]) &&
                pin_o[12] == $past(port_data_i[12]) &&
                pin_o[3] == $past(port_data_i[3]) &&
                pin_o[1:0] == $past(port_data_i[1:0]));
  endproperty
  a_plain_data: assert property (p_plain_data) // RL16
    else $error("plain pins do not show their data bits");

  property p_port2_dir;
    @(posedge clk_i) disable iff (reset_i)
      (sfr_i.wr && sfr_i.addr == GPM_PORT2_CFG_ADDR)
      |=> ##1 (pin_oe_o[15:8] == $past(sfr_i.wdata, 2));
  endproperty
  a_port2_dir: assert property (p_port2_dir) // RL15
    else $error("port 2 direction does not follow configuration");

  property p_port3_dir;
    @(posedge clk_i) disable iff (reset_i || $past(reset_i))
      !$past(periph_i.i2c_en) |-> pin_oe_o[23:16] == $past(port3_cfg_i);
  endproperty
  a_port3_dir: assert property (p_port3_dir) // RL2
    else $error("port 3 direction does not follow its configuration");

  property p_idle_read;
    @(posedge clk_i) disable iff (reset_i)
      !sfr_i.rd |=> (!sfr_hit_o && sfr_rdata_o == GPM_RDATA_UNMAPPED);
  endproperty
  a_idle_read: assert property (p_idle_read) // RL18
    else $error("read data does not return to idle");

endmodule

`default_nettype wire

/* File: design/gpm_pkg.sv */
// Behaviour
// RL1: After reset every pin is an input; no pin drives.
// RL2: Twenty-four pins, each with its own direction and function.
// RL3: Ports are bidirectional: output data is driven, pin levels are read back.
// RL4: Pin function comes from its configuration bit and the peripheral's enable.
// RL5: An output pin carries an enabled peripheral's signal, e.g. port 2 bit 5 SPI clock.
// RL6: Software sets peripheral output pins to output and input pins to input.
// RL7: I2C clock and data pin direction is steered by the I2C logic itself.
// RL8: Port 0 bit 3: 0 input feeding second UART receive, 1 output.
// RL9: Port 0 bit 2: 0 input, 1 output with data or second UART transmit.
// RL10: Port 0 bit 1: 0 input feeding timer external control, 1 output.
// RL11: Port 0 bit 0: 0 input feeding timer count input, 1 output.
// RL12: Upper four bits of port 0 and port 1 configuration affect no pin.
// RL13: Port 1 bits 3..0: 0 input, 1 output with data or PWM channel.
// RL14: Software sets port 1 bits of PWM channels in use to 1.
// RL15: Port 2 bits route SPI data in, data out, clock, select, chip selects 0..3.
// RL16: An output pin shows its port data register bit.
// RL17: Port read returns the pin level for pins configured as inputs.
// RL18: Configuration registers reset to zero and are readable and writable.
package gpm_pkg;

  localparam logic [7:0] GPM_PORT0_CFG_ADDR = 8'h9b;
  localparam logic [7:0] GPM_PORT1_CFG_ADDR = 8'h9c;
  localparam logic [7:0] GPM_PORT2_CFG_ADDR = 8'h9d;
  localparam logic [7:0] GPM_CFG_RESET      = 8'h00;
  localparam logic [7:0] GPM_RDATA_UNMAPPED = 8'h00;

  localparam int GPM_NPINS = 24;

  // Pin index = position in the 24-bit pin vectors
  localparam int GPM_PIN_TB_CNT  = 0;
  localparam int GPM_PIN_TB_EXT  = 1;
  localparam int GPM_PIN_UB_TX   = 2;
  localparam int GPM_PIN_UB_RX   = 3;
  localparam int GPM_PIN_PWM0    = 4;
  localparam int GPM_PIN_CS3     = 8;
  localparam int GPM_PIN_CS0     = 11;
  localparam int GPM_PIN_SS      = 12;
  localparam int GPM_PIN_SCK     = 13;
  localparam int GPM_PIN_SDO     = 14;
  localparam int GPM_PIN_SDI     = 15;
  localparam int GPM_PIN_I2C_SDA = 22;
  localparam int GPM_PIN_I2C_SCL = 23;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } gpm_sfr_req_t;

  typedef struct packed {
    logic       uart_b_en;
    logic       uart_b_tx;
    logic       pwm_en;
    logic [3:0] pwm;
    logic       spi_en;
    logic       spi_sdo;
    logic       spi_sck;
    logic [3:0] spi_cs;
    logic       i2c_en;
    logic       i2c_scl_oe;
    logic       i2c_sda_oe;
  } gpm_periph_out_t;

  typedef struct packed {
    logic uart_b_rx;
    logic timer_b_ext;
    logic timer_b_cnt;
    logic spi_sdi;
    logic spi_sck;
    logic spi_ss;
    logic i2c_scl;
    logic i2c_sda;
  } gpm_periph_in_t;

  typedef struct packed {
    logic [7:0]           cfg0;
    logic [7:0]           cfg1;
    logic [7:0]           cfg2;
    logic [7:0]           rdata;
    logic                 hit;
    logic [GPM_NPINS-1:0] pin_out;
    logic [GPM_NPINS-1:0] pin_oe;
    logic [GPM_NPINS-1:0] port_read;
    gpm_periph_in_t       pin_in;
  } gpm_state_t;

endpackage

/* File: tb/gpm_ext_dev.sv */
`timescale 1ns/10ps
`default_nettype none

module gpm_ext_dev
  import gpm_pkg::*;
(
  input  wire logic [GPM_NPINS-1:0] dut_out_i,
  input  wire logic [GPM_NPINS-1:0] dut_oe_i,
  input  wire logic [GPM_NPINS-1:0] drv_en_i,
  input  wire logic [GPM_NPINS-1:0] drv_val_i,
  output logic [GPM_NPINS-1:0]      level_o
);
  // Far side drives only pins left as inputs; an undriven pin sits at the pull-up
  assign level_o = (dut_oe_i & dut_out_i) | (~dut_oe_i & drv_en_i & drv_val_i)
                 | (~dut_oe_i & ~drv_en_i);
endmodule

`default_nettype wire

/* File: tb/gpio_pin_direction_mux_bench.sv */
`timescale 1ns/10ps
`default_nettype none

module gpio_pin_direction_mux_bench;
  import gpm_pkg::*;
  logic            clk_i = 1'b0;
  logic            reset_i = 1'b1;
  gpm_sfr_req_t    sfr = '0;
  gpm_periph_out_t po = '0;
  gpm_periph_in_t  pi;
  logic [7:0]      rdata;
  logic            hit;
  logic [7:0]      p3 = 8'h00;
  logic [23:0]     pd = 24'h000000;
  logic [23:0]     den = 24'h000000;
  logic [23:0]     dval = 24'h000000;
  logic [23:0]     lvl, pout, poe, prd, eo;
  logic [7:0]      cfg_m [3];
  logic [31:0]     v;
  int              seed = 11;
  int              err_count = 0;
  int              comparisons = 0;

  gpm_pin_mux u_gpm_pin_mux (.clk_i(clk_i), .reset_i(reset_i), .sfr_i(sfr),
    .sfr_rdata_o(rdata), .sfr_hit_o(hit), .port3_cfg_i(p3), .port_data_i(pd),
    .periph_i(po), .periph_o(pi), .pin_i(lvl), .pin_o(pout), .pin_oe_o(poe),
    .port_read_o(prd));
  gpm_ext_dev u_gpm_ext_dev (.dut_out_i(pout), .dut_oe_i(poe), .drv_en_i(den),
    .drv_val_i(dval), .level_o(lvl));

  always #2.5 clk_i = ~clk_i;

  task automatic give_verdict();
    if (err_count == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic cmp_reg(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cmp_pin(input logic [23:0] got, input logic [23:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic tick();
    @(posedge clk_i);
    #1;
  endtask

  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
    sfr.wr = 1'b1;
    sfr.addr = a;
    sfr.wdata = d;
    tick();
    sfr.wr = 1'b0;
    tick();
  endtask

  task automatic sfr_rd(input logic [7:0] a, input logic [7:0] d, input logic h);
    sfr.rd = 1'b1;
    sfr.addr = a;
    tick();
    sfr.rd = 1'b0;
    cmp_reg(rdata, d);
    cmp_reg({7'h00, hit}, {7'h00, h});
    tick();
  endtask

  function automatic logic [23:0] exp_oe();
    logic [23:0] e;
    e = {p3, cfg_m[2], cfg_m[1][3:0], cfg_m[0][3:0]};
    if (po.i2c_en) e[23:22] = {po.i2c_scl_oe, po.i2c_sda_oe};
    return e;
  endfunction

  function automatic logic [23:0] exp_out();
    logic [23:0] e;
    e = pd;
    if (po.uart_b_en) e[2] = po.uart_b_tx;
    if (po.pwm_en) e[7:4] = po.pwm;
    if (po.spi_en) begin
      e[14:13] = {po.spi_sdo, po.spi_sck};
      e[11:8] = {po.spi_cs[0], po.spi_cs[1], po.spi_cs[2], po.spi_cs[3]};
    end
    if (po.i2c_en) e[23:22] = 2'b00;
    return e;
  endfunction

  initial begin
    #200000;
    err_count++;
    give_verdict();
  end

  initial begin
    cfg_m = '{8'h00, 8'h00, 8'h00};
    repeat (10) tick();
    cmp_pin(poe, 24'h000000);
    reset_i = 1'b0;
    tick();
    for (int i = 0; i < 4; i++) sfr_rd(GPM_PORT0_CFG_ADDR + 8'(i), 8'h00, i < 3);
    // Random writes over the three registers and both unmapped neighbours
    for (int n = 0; n < 30; n++) begin
      v = $random(seed);
      v[7:0] = 8'h9a + 8'(v[31:8] % 5);
      sfr_wr(v[7:0], v[15:8]);
      if (v[7:0] inside {8'h9b, 8'h9c, 8'h9d}) cfg_m[v[7:0] - 8'h9b] = v[15:8];
      for (int i = 0; i < 3; i++) sfr_rd(GPM_PORT0_CFG_ADDR + 8'(i), cfg_m[i], 1'b1);
      sfr_rd(8'h9e, 8'h00, 1'b0);
    end
    for (int n = 0; n < 40; n++) begin
      v = $random(seed);
      if (n == 0) v = 32'hffffffff;
      if (n == 1) v = 32'h006f0f04;
      for (int i = 0; i < 3; i++) begin
        sfr_wr(GPM_PORT0_CFG_ADDR + 8'(i), v[8*i +: 8]);
        cfg_m[i] = v[8*i +: 8];
      end
      p3 = v[31:24];
      v = $random(seed);
      // Corner cases: all peripherals off, then all four enables on
      if (n == 0) v[16:0] = 17'h00000;
      if (n == 1) v[16:0] = v[16:0] | 17'h14204;
      po = v[16:0];
      pd = v[31:8];
      v = $random(seed);
      den = v[23:0];
      v = $random(seed);
      dval = v[23:0];
      repeat (2) tick();
      eo = exp_oe();
      cmp_pin(poe, eo);
      cmp_pin(pout, exp_out());
      cmp_pin(prd, (eo & pd) | (~eo & lvl));
      cmp_pin({16'h0000, pi}, {16'h0000, lvl[3], lvl[1:0], lvl[15], lvl[13:12],
        lvl[23:22]});
    end
    // Write and read of one register back to back, then in the same cycle
    sfr.wr = 1'b1;
    sfr.addr = GPM_PORT2_CFG_ADDR;
    sfr.wdata = 8'h5a;
    tick();
    sfr.wr = 1'b0;
    sfr_rd(GPM_PORT2_CFG_ADDR, 8'h5a, 1'b1);
    sfr.wr = 1'b1;
    sfr.wdata = 8'ha5;
    sfr_rd(GPM_PORT2_CFG_ADDR, 8'h5a, 1'b1);
    sfr.wr = 1'b0;
    sfr_rd(GPM_PORT2_CFG_ADDR, 8'ha5, 1'b1);
    reset_i = 1'b1;
    repeat (2) tick();
    p3 = 8'h00;
    cmp_pin(poe, {16'h0000, 8'h00});
    reset_i = 1'b0;
    tick();
    for (int i = 0; i < 3; i++) sfr_rd(GPM_PORT0_CFG_ADDR + 8'(i), GPM_CFG_RESET, 1'b1);
    give_verdict();
  end
endmodule

`default_nettype wire
